// ### src/cpc_top.sv
// Camera capture port: register file, pixel capture and packing
`timescale 1ns/100ps
module cpc_top #(
	parameter int         DEPTH     = cpc_pkg::CPC_FIFO_DEPTH,
	parameter logic [7:0] REV_MAJOR = 8'h01,
	parameter logic [7:0] REV_MINOR = 8'h00
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        pixClk,
	input  wire logic        hsync,
	input  wire logic        vsync,
	input  wire logic [11:0] sensorPixelBus,
	output logic             dmaReq,
	output logic             captureIrq,
	output logic             neuralNetModeEnable
);
	import cpc_pkg::*;

	// REV_MAJOR and REV_MINOR defaults are arbitrary values
	localparam int LW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || DEPTH > 255) begin : gBadDepth
			$error("cpc_top: DEPTH must lie in 2..255");
		end
	endgenerate

	cpc_fifo_if #(.WIDTH(CPC_WORD_W), .LW(LW)) fifoIf ();

	cpc_fifo #(.DEPTH(DEPTH), .WIDTH(CPC_WORD_W)) uFifo (
		.clk    (clk),
		.arst_n (arst_n),
		.fifo   (fifoIf.store)
	);

	// Pin synchronisers; the third clock stage only feeds edge detection
	logic        pclkS1, pclkS2, pclkS3;
	logic        hsS1, hsS2;
	logic        vsS1, vsS2;
	logic [11:0] pixS1, pixS2;
	logic        pclkRise;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pclkS1 <= 1'b0;
			pclkS2 <= 1'b0;
			pclkS3 <= 1'b0;
			hsS1   <= 1'b0;
			hsS2   <= 1'b0;
			vsS1   <= 1'b0;
			vsS2   <= 1'b0;
			pixS1  <= 12'h000;
			pixS2  <= 12'h000;
		end else begin
			pclkS1 <= pixClk;
			pclkS2 <= pclkS1;
			pclkS3 <= pclkS2;
			hsS1   <= hsync;
			hsS2   <= hsS1;
			vsS1   <= vsync;
			vsS2   <= vsS1;
			pixS1  <= sensorPixelBus;
			pixS2  <= pixS1;
		end
	end

	// Data changes on the falling pixel edge, so it is settled here
	assign pclkRise = pclkS2 & ~pclkS3;

	// Register state
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] ie_reg, ie_next;
	logic [31:0] codes_reg, codes_next;
	logic        done_reg, done_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;

	// Capture state
	cpc_state_e  state_reg, state_next;
	logic [31:0] word_reg, word_next;
	logic [1:0]  cnt_reg, cnt_next;
	logic        vsPrev_reg, vsPrev_next;

	logic        req, wr, rd;
	logic [7:0]  adrWord;
	logic [31:0] byteMask;
	logic [31:0] statusBits;
	logic [7:0]  lvl8;
	logic [7:0]  dmaThr8;
	logic [7:0]  fifoThr8;
	logic        doneEvt;
	logic        singleDone;
	logic        wordDone;
	logic        captureOn;
	logic        codeTiming;
	logic [11:0] pixMasked;
	logic [7:0]  pixByte;
	logic        rdRev;
	cpc_mode_e   mode;

	assign mode       = cpc_mode_e'(ctrl_reg[CPC_MODE_LSB +: 2]);
	assign codeTiming = ctrl_reg[CPC_TIMING_BIT];
	assign captureOn  = ctrl_reg[CPC_EN_BIT]
		& (mode == CPC_MODE_SINGLE || mode == CPC_MODE_CONT);
	assign lvl8       = 8'(fifoIf.level);
	assign dmaThr8    = 8'(ctrl_reg[CPC_DMATHR_LSB +: CPC_DMATHR_W]);
	assign fifoThr8   = 8'(ctrl_reg[CPC_FTHR_LSB +: CPC_FTHR_W]);

	// Live status from the store level, plus the sticky image done flag
	always_comb begin
		statusBits                = 32'h0000_0000;
		statusBits[CPC_FL_NEMPTY] = !fifoIf.empty;
		statusBits[CPC_FL_THRESH] = (lvl8 >= fifoThr8);
		statusBits[CPC_FL_FULL]   = fifoIf.full;
		statusBits[CPC_FL_DONE]   = done_reg;
	end

	// Level outputs; dropping the enable drops the request at once
	assign captureIrq          = |(ie_reg[3:0] & statusBits[3:0]);
	assign dmaReq              = ctrl_reg[CPC_DMAEN_BIT] && (lvl8 >= dmaThr8);
	assign neuralNetModeEnable = ctrl_reg[CPC_NN_BIT];
	assign wb_ack_o            = ack_reg;
	assign wb_dat_o            = rdat_reg;

	// Pixel width select; unused upper lines are forced low
	always_comb begin
		case (cpc_width_e'(ctrl_reg[CPC_WIDTH_LSB +: 2]))
			CPC_PIX_10: begin
				pixMasked = {2'b00, pixS2[9:0]};
			end
			CPC_PIX_12: begin
				pixMasked = pixS2;
			end
			default: begin
				pixMasked = {4'h0, pixS2[7:0]};
			end
		endcase
	end
	assign pixByte = pixMasked[7:0];

	// Capture sequencer and packer
	always_comb begin
		state_next  = state_reg;
		word_next   = word_reg;
		cnt_next    = cnt_reg;
		vsPrev_next = vsPrev_reg;
		doneEvt     = 1'b0;
		wordDone    = 1'b0;
		if (!captureOn) begin
			state_next = CPC_ST_IDLE;
			cnt_next   = 2'b00;
		end else if (pclkRise) begin
			vsPrev_next = vsS2;
			case (state_reg)
				CPC_ST_IDLE: begin
					state_next = CPC_ST_WAIT;
				end
				CPC_ST_WAIT: begin
					cnt_next = 2'b00;
					if (codeTiming) begin
						if (pixByte == codes_reg[7:0]) begin
							state_next = CPC_ST_ACTIVE;
						end
					end else if (vsS2 && !vsPrev_reg && hsS2) begin
						state_next = CPC_ST_ACTIVE;
					end
				end
				CPC_ST_ACTIVE: begin
					if (codeTiming ? (pixByte == codes_reg[15:8])
						: (vsS2 && !vsPrev_reg)) begin
						doneEvt    = 1'b1;
						state_next = (mode == CPC_MODE_SINGLE) ? CPC_ST_IDLE : CPC_ST_WAIT;
					end else if (codeTiming ? (pixByte != codes_reg[7:0]) : hsS2) begin
						cnt_next = cnt_reg + 2'b01;
						if (ctrl_reg[CPC_WIDTH_LSB +: 2] == CPC_PIX_8) begin
							word_next = {pixByte, word_reg[31:8]};
							wordDone  = (cnt_reg == 2'b11);
						end else begin
							word_next = {4'h0, pixMasked, word_reg[31:16]};
							wordDone  = cnt_reg[0];
						end
					end
				end
				default: begin
					state_next = CPC_ST_IDLE;
				end
			endcase
		end
	end

	assign singleDone      = doneEvt && (mode == CPC_MODE_SINGLE);
	// The store itself refuses a word while full, so its drop check sees the overflow
	assign fifoIf.push     = wordDone;
	assign fifoIf.pushData = word_next;

	// Wishbone slave: one wait state, unmapped reads give zero
	assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr       = req & wb_we_i;
	assign rd       = req & ~wb_we_i;
	assign adrWord  = {wb_adr_i[7:2], 2'b00};
	assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign rdRev    = rd && (adrWord == CPC_OFF_REV);
	assign fifoIf.pop = rd && (adrWord == CPC_OFF_DATA);

	always_comb begin
		ack_next   = req;
		ctrl_next  = ctrl_reg;
		ie_next    = ie_reg;
		codes_next = codes_reg;
		done_next  = done_reg;
		rdat_next  = rdat_reg;
		if (wr && adrWord == CPC_OFF_CTRL) begin
			ctrl_next = (ctrl_reg & ~(byteMask & CPC_CTRL_WMASK))
				| (wb_dat_i & byteMask & CPC_CTRL_WMASK);
		end
		if (wr && adrWord == CPC_OFF_IE) begin
			ie_next = (ie_reg & ~(byteMask & CPC_IE_WMASK)) | (wb_dat_i & byteMask & CPC_IE_WMASK);
		end
		if (wr && adrWord == CPC_OFF_CODES) begin
			codes_next = (codes_reg & ~(byteMask & CPC_CODES_WMASK))
				| (wb_dat_i & byteMask & CPC_CODES_WMASK);
		end
		// Hardware mode clear beats a racing software write
		if (singleDone) begin
			ctrl_next[CPC_MODE_LSB +: 2] = CPC_MODE_OFF;
		end
		// Set beats the write-one clear so no frame end is lost
		if (doneEvt) begin
			done_next = 1'b1;
		end else if (wr && adrWord == CPC_OFF_STATUS && wb_sel_i[0] && wb_dat_i[CPC_FL_DONE]) begin
			done_next = 1'b0;
		end
		if (rd) begin
			case (adrWord)
				CPC_OFF_REV: begin
					rdat_next = {16'h0000, REV_MAJOR, REV_MINOR};
				end
				CPC_OFF_DEPTH: begin
					rdat_next = {24'h00_0000, 8'(DEPTH)};
				end
				CPC_OFF_CTRL: begin
					rdat_next = ctrl_reg;
				end
				CPC_OFF_IE: begin
					rdat_next = ie_reg;
				end
				CPC_OFF_STATUS: begin
					rdat_next = statusBits;
				end
				CPC_OFF_CODES: begin
					rdat_next = codes_reg;
				end
				CPC_OFF_DATA: begin
					rdat_next = fifoIf.empty ? 32'h0000_0000 : fifoIf.popData;
				end
				default: begin
					rdat_next = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg   <= CPC_CTRL_RESET;
			ie_reg     <= CPC_IE_RESET;
			codes_reg  <= CPC_CODES_RESET;
			done_reg   <= 1'b0;
			ack_reg    <= 1'b0;
			rdat_reg   <= 32'h0000_0000;
			state_reg  <= CPC_ST_IDLE;
			word_reg   <= 32'h0000_0000;
			cnt_reg    <= 2'b00;
			vsPrev_reg <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			ie_reg     <= ie_next;
			codes_reg  <= codes_next;
			done_reg   <= done_next;
			ack_reg    <= ack_next;
			rdat_reg   <= rdat_next;
			state_reg  <= state_next;
			word_reg   <= word_next;
			cnt_reg    <= cnt_next;
			vsPrev_reg <= vsPrev_next;
		end
	end

	chk_rev_read: assert property (@(posedge clk) disable iff (!arst_n)
		$past(rdRev) |-> (wb_ack_o && wb_dat_o == {16'h0000, REV_MAJOR, REV_MINOR}))
		else $error("revision read gave wrong data");

	chk_enable_idle: assert property (@(posedge clk) disable iff (!arst_n)
		!ctrl_reg[CPC_EN_BIT] |=> (state_reg == CPC_ST_IDLE && !fifoIf.push))
		else $error("capture ran while disabled");

	chk_dma_off: assert property (@(posedge clk) disable iff (!arst_n)
		!ctrl_reg[CPC_DMAEN_BIT] |-> !dmaReq)
		else $error("DMA request while DMA disabled");

	chk_dma_level: assert property (@(posedge clk) disable iff (!arst_n)
		(ctrl_reg[CPC_DMAEN_BIT] && dmaThr8 != 8'h00 && lvl8 >= dmaThr8) |-> dmaReq)
		else $error("DMA request missing at threshold");

	chk_irq_nempty: assert property (@(posedge clk) disable iff (!arst_n)
		(ie_reg[CPC_FL_NEMPTY] && !fifoIf.empty) |-> captureIrq)
		else $error("not-empty interrupt missing");

	chk_irq_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		(ie_reg[3:0] == 4'h0) |-> !captureIrq)
		else $error("interrupt with all enables off");

	chk_single_clear: assert property (@(posedge clk) disable iff (!arst_n)
		singleDone |=> (mode == CPC_MODE_OFF && done_reg) ##1 (state_reg == CPC_ST_IDLE))
		else $error("single image did not stop");

	chk_done_clear: assert property (@(posedge clk) disable iff (!arst_n)
		(wr && adrWord == CPC_OFF_STATUS && wb_sel_i[0] && wb_dat_i[0] && !doneEvt)
		|=> !done_reg)
		else $error("write one did not clear image done");

	chk_full_flag: assert property (@(posedge clk) disable iff (!arst_n)
		(fifoIf.push && !fifoIf.pop && lvl8 == 8'(DEPTH - 1)) |=> statusBits[CPC_FL_FULL])
		else $error("full flag missing");
endmodule // cpc_top

// ### src/cpc_pkg.sv
// Shared constants and types of the camera capture port
package cpc_pkg;
	// Register byte offsets
	localparam logic [7:0]  CPC_OFF_REV    = 8'h00;
	localparam logic [7:0]  CPC_OFF_DEPTH  = 8'h04;
	localparam logic [7:0]  CPC_OFF_CTRL   = 8'h08;
	localparam logic [7:0]  CPC_OFF_IE     = 8'h0C;
	localparam logic [7:0]  CPC_OFF_STATUS = 8'h10;
	localparam logic [7:0]  CPC_OFF_CODES  = 8'h14;
	localparam logic [7:0]  CPC_OFF_DATA   = 8'h30;
	// Control field positions
	localparam int          CPC_EN_BIT     = 31;
	localparam int          CPC_NN_BIT     = 30;
	localparam int          CPC_DMATHR_LSB = 17;
	localparam int          CPC_DMATHR_W   = 4;
	localparam int          CPC_DMAEN_BIT  = 16;
	localparam int          CPC_FTHR_LSB   = 5;
	localparam int          CPC_FTHR_W     = 5;
	localparam int          CPC_TIMING_BIT = 4;
	localparam int          CPC_WIDTH_LSB  = 2;
	localparam int          CPC_MODE_LSB   = 0;
	// Status and enable bit positions
	localparam int          CPC_FL_NEMPTY  = 3;
	localparam int          CPC_FL_THRESH  = 2;
	localparam int          CPC_FL_FULL    = 1;
	localparam int          CPC_FL_DONE    = 0;
	// Reset values, writable masks and store sizes
	localparam logic [31:0] CPC_CTRL_RESET  = 32'h0002_0020;
	localparam logic [31:0] CPC_CTRL_WMASK  = 32'hC01F_03FF;
	localparam logic [31:0] CPC_IE_RESET    = 32'h0000_0000;
	localparam logic [31:0] CPC_IE_WMASK    = 32'h0000_000F;
	localparam logic [31:0] CPC_CODES_RESET = 32'h0000_9D80;
	localparam logic [31:0] CPC_CODES_WMASK = 32'h0000_FFFF;
	localparam int          CPC_FIFO_DEPTH  = 8;
	localparam int          CPC_WORD_W      = 32;

	typedef enum logic [1:0] {
		CPC_MODE_OFF    = 2'b00,
		CPC_MODE_SINGLE = 2'b01,
		CPC_MODE_CONT   = 2'b10,
		CPC_MODE_RSVD   = 2'b11
	} cpc_mode_e;

	typedef enum logic [1:0] {
		CPC_PIX_8    = 2'b00,
		CPC_PIX_10   = 2'b01,
		CPC_PIX_12   = 2'b10,
		CPC_PIX_RSVD = 2'b11
	} cpc_width_e;

	typedef enum logic [1:0] {
		CPC_ST_IDLE   = 2'b00,
		CPC_ST_WAIT   = 2'b01,
		CPC_ST_ACTIVE = 2'b10
	} cpc_state_e;
endpackage

// ### src/cpc_fifo_if.sv
// Push and pop signals between the capture logic and its word store
`timescale 1ns/100ps
interface cpc_fifo_if #(
	parameter int WIDTH = 32,
	parameter int LW    = 4
) ();
	logic             push;
	logic [WIDTH-1:0] pushData;
	logic             pop;
	logic [WIDTH-1:0] popData;
	logic [LW-1:0]    level;
	logic             full;
	logic             empty;

	modport writer (output push, pushData, pop, input popData, level, full, empty);
	modport store  (input push, pushData, pop, output popData, level, full, empty);
endinterface

// ### src/cpc_fifo.sv
// Word store of the camera capture port
`timescale 1ns/100ps
module cpc_fifo #(
	parameter int DEPTH = cpc_pkg::CPC_FIFO_DEPTH,
	parameter int WIDTH = cpc_pkg::CPC_WORD_W
) (
	input wire logic clk,
	input wire logic arst_n,
	cpc_fifo_if.store fifo
);
	import cpc_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || DEPTH > 255) begin : gBadDepth
			$error("cpc_fifo: DEPTH must lie in 2..255");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_reg, wrPtr_next;
	logic [PW-1:0]    rdPtr_reg, rdPtr_next;
	logic [LW-1:0]    count_reg, count_next;
	logic             doPush;
	logic             doPop;

	assign fifo.full    = (count_reg == LW'(DEPTH));
	assign fifo.empty   = (count_reg == '0);
	assign fifo.level   = count_reg;
	assign fifo.popData = mem[rdPtr_reg];

	always_comb begin
		// A full store drops the new word instead of overwriting
		doPush     = fifo.push & ~fifo.full;
		doPop      = fifo.pop & ~fifo.empty;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (doPush) begin
			wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		end
		if (doPop) begin
			rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		if (doPush && !doPop) begin
			count_next = count_reg + 1'b1;
		end else if (doPop && !doPush) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end

	// Storage needs no reset; empty reads are masked by the reader
	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_reg] <= fifo.pushData;
		end
	end

	chk_pop_level: assert property (@(posedge clk) disable iff (!arst_n)
		(fifo.pop && !fifo.empty && !fifo.push) |=> (count_reg == $past(count_reg) - 1'b1))
		else $error("pop did not lower the level by one");

	chk_full_drop: assert property (@(posedge clk) disable iff (!arst_n)
		(fifo.full && fifo.push && !fifo.pop) |=> (fifo.full && wrPtr_reg == $past(wrPtr_reg)))
		else $error("push into full store changed it");
endmodule // cpc_fifo

// ### verif/cpc_sensor_model.sv
// Behavioural parallel-output image sensor for the capture port bench
`timescale 1ns/100ps
module cpc_sensor_model (
	output logic        pixClk,
	output logic        hsync,
	output logic        vsync,
	output logic [11:0] pixBus
);
	initial begin
		pixClk = 1'b0;
		hsync  = 1'b0;
		vsync  = 1'b0;
		pixBus = 12'h000;
	end

	// Lines change while the pixel clock is low, so they are stable at its rise
	task automatic beat(input logic h, input logic v, input logic [11:0] d);
		hsync  = h;
		vsync  = v;
		pixBus = d;
		#24 pixClk = 1'b1;
		#24 pixClk = 1'b0;
	endtask

	// Clock stands still between frames; the bus stops showing the last pixel
	task automatic idle();
		hsync  = 1'b0;
		pixBus = ~pixBus;
		#120;
	endtask

	// Sync framing: vsync rise with hsync high opens, the next vsync rise closes
	task automatic sync_frame(input int n, input logic [7:0] base);
		beat(1'b0, 1'b0, 12'h000);
		beat(1'b1, 1'b1, 12'h000);
		beat(1'b0, 1'b0, 12'h000);
		for (int i = 0; i < n; i++) begin
			beat(1'b1, 1'b0, {4'hF, base + i[7:0]});
		end
		beat(1'b0, 1'b1, 12'h000);
		idle();
	endtask

	// Embedded framing; sync lines toggle to show they are ignored
	// Leading filler edge lets a freshly enabled port arm before the start code
	task automatic code_frame(
		input logic [11:0] sav,
		input logic [11:0] p0,
		input logic [11:0] p1,
		input logic [11:0] eav
	);
		beat(1'b0, 1'b0, 12'h000);
		beat(1'b1, 1'b0, sav);
		beat(1'b1, 1'b1, p0);
		beat(1'b1, 1'b0, p1);
		beat(1'b1, 1'b1, eav);
		idle();
	endtask
endmodule // cpc_sensor_model

// ### verif/cpc_top_test.sv
// Self-checking bench of the camera capture port
`timescale 1ns/100ps
module cpc_top_test;
	import cpc_pkg::*;
	localparam int LIMIT = 20000;
	logic        clk;
	logic        arst_n;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatW;
	logic [31:0] wbDatR;
	logic        wbAck;
	logic        pixClk;
	logic        hsync;
	logic        vsync;
	logic [11:0] pixBus;
	logic        dmaReq;
	logic        captureIrq;
	logic        nnMode;
	int          errCount = 0;
	int          comparisons = 0;
	int          cycles = 0;

	cpc_top #(.REV_MAJOR(8'h5A), .REV_MINOR(8'h3C)) dut (
		.clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
		.wb_ack_o(wbAck), .pixClk(pixClk), .hsync(hsync), .vsync(vsync),
		.sensorPixelBus(pixBus), .dmaReq(dmaReq), .captureIrq(captureIrq),
		.neuralNetModeEnable(nnMode)
	);
	cpc_sensor_model sensor (.pixClk(pixClk), .hsync(hsync), .vsync(vsync), .pixBus(pixBus));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errCount++;
			giveVerdict();
		end
	end

	task automatic giveVerdict();
		if (errCount == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	// Classic cycle; ack and read data are taken at the same sampled edge
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'hF;
		wbDatW <= d;
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		check(q, exp);
	endtask

	task automatic test_reset_values();
		rd(CPC_OFF_REV, 32'h0000_5A3C);
		rd(CPC_OFF_DEPTH, 32'h0000_0008);
		rd(CPC_OFF_CTRL, 32'h0002_0020);
		rd(CPC_OFF_IE, 32'h0000_0000);
		rd(CPC_OFF_STATUS, 32'h0000_0000);
		rd(CPC_OFF_CODES, 32'h0000_9D80);
		rd(CPC_OFF_DATA, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		check({31'h0, nnMode}, 32'h0000_0000);
	endtask

	task automatic test_access();
		wr(CPC_OFF_CTRL, 32'hFFFF_FFFC);
		rd(CPC_OFF_CTRL, 32'hC01F_03FC);
		check({31'h0, nnMode}, 32'h0000_0001);
		wr(CPC_OFF_IE, 32'hFFFF_FFFF);
		rd(CPC_OFF_IE, 32'h0000_000F);
		check({31'h0, captureIrq}, 32'h0000_0000);
		wr(CPC_OFF_REV, 32'hFFFF_FFFF);
		wr(CPC_OFF_DEPTH, 32'hFFFF_FFFF);
		rd(CPC_OFF_REV, 32'h0000_5A3C);
		rd(CPC_OFF_DEPTH, 32'h0000_0008);
		wr(CPC_OFF_IE, 32'h0000_0000);
		wr(CPC_OFF_CTRL, 32'h0000_0000);
	endtask

	task automatic test_sync_single();
		wr(CPC_OFF_CTRL, 32'h8005_0041);
		sensor.sync_frame(8, 8'h11);
		rd(CPC_OFF_CTRL, 32'h8005_0040);
		rd(CPC_OFF_STATUS, 32'h0000_000D);
		check({31'h0, dmaReq}, 32'h0000_0001);
		wr(CPC_OFF_IE, 32'h0000_0001);
		check({31'h0, captureIrq}, 32'h0000_0001);
		wr(CPC_OFF_STATUS, 32'h0000_0000);
		rd(CPC_OFF_STATUS, 32'h0000_000D);
		wr(CPC_OFF_STATUS, 32'hFFFF_FFFF);
		rd(CPC_OFF_STATUS, 32'h0000_000C);
		check({31'h0, captureIrq}, 32'h0000_0000);
		wr(CPC_OFF_IE, 32'h0000_0004);
		check({31'h0, captureIrq}, 32'h0000_0001);
		// DMA enable dropped while the level still meets the DMA threshold
		wr(CPC_OFF_CTRL, 32'h8004_0040);
		check({31'h0, dmaReq}, 32'h0000_0000);
		rd(CPC_OFF_DATA, 32'h1413_1211);
		rd(CPC_OFF_STATUS, 32'h0000_0008);
		check({31'h0, captureIrq}, 32'h0000_0000);
		wr(CPC_OFF_IE, 32'h0000_0008);
		check({31'h0, captureIrq}, 32'h0000_0001);
		rd(CPC_OFF_DATA, 32'h1817_1615);
		rd(CPC_OFF_STATUS, 32'h0000_0000);
		check({31'h0, captureIrq}, 32'h0000_0000);
		wr(CPC_OFF_IE, 32'h0000_0000);
		wr(CPC_OFF_CTRL, 32'h0000_0000);
	endtask

	task automatic test_embedded();
		logic [11:0] mask;
		logic [31:0] ctrl;
		wr(CPC_OFF_CODES, 32'h0000_E1F0);
		rd(CPC_OFF_CODES, 32'h0000_E1F0);
		for (int w = 1; w <= 2; w++) begin
			mask = (w == 1) ? 12'h3FF : 12'hFFF;
			ctrl = 32'h8000_0032 | (32'(w) << 2);
			wr(CPC_OFF_CTRL, ctrl);
			sensor.code_frame(12'hAF0, 12'hFBC, 12'h523, 12'hCE1);
			rd(CPC_OFF_CTRL, ctrl);
			rd(CPC_OFF_STATUS, 32'h0000_000D);
			rd(CPC_OFF_DATA, {4'h0, 12'h523 & mask, 4'h0, 12'hFBC & mask});
			wr(CPC_OFF_STATUS, 32'h0000_0001);
			rd(CPC_OFF_STATUS, 32'h0000_0000);
		end
		wr(CPC_OFF_CTRL, 32'h0000_0000);
	endtask

	// Nine words offered to an eight-word store
	task automatic test_overflow();
		logic [7:0] b;
		wr(CPC_OFF_CTRL, 32'h8000_0102);
		sensor.sync_frame(36, 8'h40);
		rd(CPC_OFF_STATUS, 32'h0000_000F);
		wr(CPC_OFF_IE, 32'h0000_0002);
		check({31'h0, captureIrq}, 32'h0000_0001);
		rd(CPC_OFF_DATA, 32'h4342_4140);
		rd(CPC_OFF_STATUS, 32'h0000_0009);
		check({31'h0, captureIrq}, 32'h0000_0000);
		for (int k = 1; k < 8; k++) begin
			b = 8'(8'h40 + 4 * k);
			rd(CPC_OFF_DATA, {b + 8'h03, b + 8'h02, b + 8'h01, b});
		end
		rd(CPC_OFF_DATA, 32'h0000_0000);
		wr(CPC_OFF_IE, 32'h0000_0000);
		wr(CPC_OFF_CTRL, 32'h0000_0000);
	endtask

	task automatic test_reset_again();
		wr(CPC_OFF_CTRL, 32'hC000_0000);
		wr(CPC_OFF_IE, 32'h0000_000F);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(CPC_OFF_CTRL, 32'h0002_0020);
		rd(CPC_OFF_IE, 32'h0000_0000);
		check({31'h0, nnMode}, 32'h0000_0000);
	endtask

	initial begin
		arst_n = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDatW = 32'h0000_0000;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		test_reset_values();
		test_access();
		test_sync_single();
		test_embedded();
		test_overflow();
		test_reset_again();
		giveVerdict();
	end
endmodule // cpc_top_test
